// File: design/pvi_params.svh
// Timing counts and message codes shared by both ends of the voltage-increase sequencer.
`ifndef PVI_PARAMS_SVH
`define PVI_PARAMS_SVH

// ----------------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------------
// Local clock period in nanoseconds (20 MHz).
`define PVI_CLK_PERIOD_NS 50
// Default tSnkTransition wait in microseconds (plain default, no figure given).
`define PVI_SNK_TRANSITION_US 30
// Default tSrcReady limit in microseconds (plain default).
`define PVI_SRC_READY_US 200
// Default tSnkStdby limit in microseconds (plain default).
`define PVI_SNK_STDBY_US 20
// Default sink transition supervision timer in microseconds (plain default).
`define PVI_PS_TRANSITION_US 400
// Least wait rounds up to whole cycles.
`define PVI_SNK_TRANSITION_CYC ((`PVI_SNK_TRANSITION_US * 1000 + `PVI_CLK_PERIOD_NS - 1) / `PVI_CLK_PERIOD_NS)
// Longest times round down.
`define PVI_SRC_READY_CYC ((`PVI_SRC_READY_US * 1000) / `PVI_CLK_PERIOD_NS)
`define PVI_SNK_STDBY_CYC ((`PVI_SNK_STDBY_US * 1000) / `PVI_CLK_PERIOD_NS)
`define PVI_PS_TRANSITION_CYC ((`PVI_PS_TRANSITION_US * 1000) / `PVI_CLK_PERIOD_NS)
// Counter width.
`define PVI_CNT_W 16

// ----------------------------------------------------------------------------
// Message codes on the link
// ----------------------------------------------------------------------------
`define PVI_MSG_NONE 2'h0
`define PVI_MSG_ACCEPT 2'h1
`define PVI_MSG_PS_RDY 2'h2
`define PVI_MSG_GOODCRC 2'h3

`endif

// File: design/pvi_pkg.sv
// Types shared by the two ends of the voltage-increase sequencer.
package pvi_pkg;
    // Message type carried on the link.
    typedef logic [1:0] pvi_msg_t;
endpackage

// File: design/pvi_link_if.sv
// Link between the source end and the sink end of the voltage-increase sequencer.
`timescale 1ns/1ps
`default_nettype none
interface pvi_link_if;
    import pvi_pkg::*;
    // Source to sink: message strobe and code.
    logic src_msg_valid;
    pvi_msg_t src_msg;
    // Sink to source: message strobe and code.
    logic snk_msg_valid;
    pvi_msg_t snk_msg;

    modport source (output src_msg_valid, output src_msg, input snk_msg_valid, input snk_msg);
    modport sink (input src_msg_valid, input src_msg, output snk_msg_valid, output snk_msg);
endinterface
`default_nettype wire

// File: design/pvi_sink.sv
// Sink end: answers Accept and PS_RDY, sequences standby and resume.
`timescale 1ns/1ps
`default_nettype none
`include "pvi_params.svh"
module pvi_sink
    import pvi_pkg::*;
#(
    parameter int unsigned STDBY_CYC = `PVI_SNK_STDBY_CYC,
    parameter int unsigned PS_TRANS_CYC = `PVI_PS_TRANSITION_CYC
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    pvi_link_if.sink link,
    input wire logic stdby_reached_i,   // Supply reports consumption at standby level.
    output logic stdby_req_o,           // Ask supply to drop to standby power.
    output logic new_level_ok_o,        // Operation at new level permitted.
    output logic stdby_late_o,          // Standby not reached within limit (sticky).
    output logic ps_timeout_o           // Transition timer expired before PS_RDY (sticky).
);
    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    typedef enum {SK_IDLE, SK_WAIT_RDY, SK_DONE} pvi_sk_e;
    typedef struct packed {
        pvi_sk_e st;
        logic [`PVI_CNT_W-1:0] ps_cnt;   // Transition supervision timer.
        logic [`PVI_CNT_W-1:0] sb_cnt;   // Standby deadline counter.
        logic ack_v;
        pvi_msg_t ack;   // Code sent with the acknowledge strobe, registered.
        logic stdby_req;
        logic ok;
        logic late;
        logic tout;
    } pvi_sk_s;
    pvi_sk_s r, next_r;
    logic sb_s1, sb_s2;   // Synchroniser for the supply status pin.

    // Two flops before the supply status is read.
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sb_s1 <= 1'b0;
            sb_s2 <= 1'b0;
        end else begin
            sb_s1 <= stdby_reached_i;
            sb_s2 <= sb_s1;
        end
    end

    // Next-state logic.
    always_comb begin
        next_r = r;
        next_r.ack_v = 1'b0;
        next_r.ack = `PVI_MSG_NONE;
        // Every received message other than GoodCRC is acknowledged with GoodCRC one cycle later.
        if (link.src_msg_valid && (link.src_msg != `PVI_MSG_GOODCRC)) begin
            next_r.ack_v = 1'b1;   // see [RULE3] see [RULE8]
            next_r.ack = `PVI_MSG_GOODCRC;
        end
        unique case (r.st)
            SK_IDLE: begin
                if (link.src_msg_valid && link.src_msg == `PVI_MSG_ACCEPT) begin
                    next_r.st = SK_WAIT_RDY;
                    next_r.ps_cnt = '0;   // see [RULE2] see [RULE11]
                    next_r.sb_cnt = '0;
                    next_r.stdby_req = 1'b1;   // see [RULE5]
                    next_r.ok = 1'b0;
                end
            end
            SK_WAIT_RDY: begin
                if (r.ps_cnt < `PVI_CNT_W'(PS_TRANS_CYC)) begin
                    next_r.ps_cnt = r.ps_cnt + 1'b1;
                end else begin
                    next_r.tout = 1'b1;
                end
                // Standby must be reached before the source's wait runs out.
                if (!sb_s2) begin
                    if (r.sb_cnt < `PVI_CNT_W'(STDBY_CYC)) begin
                        next_r.sb_cnt = r.sb_cnt + 1'b1;
                    end else begin
                        next_r.late = 1'b1;   // see [RULE5]
                    end
                end
                if (link.src_msg_valid && link.src_msg == `PVI_MSG_PS_RDY) begin
                    next_r.st = SK_DONE;
                    next_r.ok = 1'b1;   // see [RULE8] see [RULE9]
                    next_r.stdby_req = 1'b0;   // see [RULE10]
                end
            end
            SK_DONE: begin
                // A fresh Accept restarts the sequence.
                if (link.src_msg_valid && link.src_msg == `PVI_MSG_ACCEPT) begin
                    next_r.st = SK_WAIT_RDY;
                    next_r.ps_cnt = '0;
                    next_r.sb_cnt = '0;
                    next_r.stdby_req = 1'b1;
                    next_r.ok = 1'b0;
                end
            end
        endcase
    end

    // State register.
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            r <= '{st: SK_IDLE, default: '0};
        end else begin
            r <= next_r;
        end
    end

    assign link.snk_msg_valid = r.ack_v;
    assign link.snk_msg = r.ack;
    assign stdby_req_o = r.stdby_req;
    assign new_level_ok_o = r.ok;
    assign stdby_late_o = r.late;
    assign ps_timeout_o = r.tout;
endmodule // pvi_sink
`default_nettype wire

// File: design/pvi_source.sv
// Source end: sequences Accept, transition wait, supply change and PS_RDY.
`timescale 1ns/1ps
`default_nettype none
`include "pvi_params.svh"

// ----------------------------------------------------------------------------
// Source sequencer
// ----------------------------------------------------------------------------
// Operation
// [RULE1] Source sends Accept after higher-voltage request.
// [RULE2] Sink starts transition timer on Accept.
// [RULE3] Sink acknowledges Accept with GoodCRC, then evaluates.
// [RULE4] Source waits tSnkTransition after Accept GoodCRC.
// [RULE5] Sink reaches standby before source wait ends.
// [RULE6] Source then commands supply; ready within tSrcReady.
// [RULE7] Supply ready forwarded; source sends PS_RDY.
// [RULE8] Sink acknowledges PS_RDY, then permits new level.
// [RULE9] Sink resume delay after PS_RDY is indeterminate.
// [RULE10] Sink respects transient load limits while ramping.
// [RULE11] Intervals counted in local clock cycles, parameterised.
module pvi_source
    import pvi_pkg::*;
#(
    parameter int unsigned SNK_TRANS_CYC = `PVI_SNK_TRANSITION_CYC,
    parameter int unsigned SRC_READY_CYC = `PVI_SRC_READY_CYC
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    pvi_link_if.source link,
    input wire logic req_accepted_i,   // Pulse: sink request for higher voltage accepted.
    input wire logic supply_ready_i,   // Supply reports ready at the new level (pin).
    output logic supply_cmd_o,         // Level: supply to move to new voltage.
    output logic busy_o,               // Sequence in progress.
    output logic done_o,               // Pulse: PS_RDY acknowledged.
    output logic ready_late_o          // Supply missed tSrcReady (sticky).
);
    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    typedef enum {SR_IDLE, SR_WAIT_ACK1, SR_TRANS, SR_WAIT_SUPPLY, SR_WAIT_ACK2} pvi_sr_e;
    typedef struct packed {
        pvi_sr_e st;
        logic [`PVI_CNT_W-1:0] cnt;   // Shared interval counter.
        logic msg_v;
        pvi_msg_t msg;
        logic cmd;
        logic done;
        logic late;
        logic busy;   // Sequence in progress, kept in a flop so the output is glitch free.
    } pvi_sr_s;
    pvi_sr_s r, next_r;
    logic rdy_s1, rdy_s2;   // Synchroniser for the supply status pin.

    // The supply status comes from outside the clock domain; two flops first.
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdy_s1 <= 1'b0;
            rdy_s2 <= 1'b0;
        end else begin
            rdy_s1 <= supply_ready_i;
            rdy_s2 <= rdy_s1;
        end
    end

    // Next-state logic; messages are one-cycle strobes.
    always_comb begin
        next_r = r;
        next_r.msg_v = 1'b0;
        next_r.msg = `PVI_MSG_NONE;
        next_r.done = 1'b0;
        unique case (r.st)
            SR_IDLE: begin
                if (req_accepted_i) begin
                    next_r.msg_v = 1'b1;
                    next_r.msg = `PVI_MSG_ACCEPT;   // see [RULE1]
                    next_r.st = SR_WAIT_ACK1;
                end
            end
            SR_WAIT_ACK1: begin
                // The wait starts only when the sink's GoodCRC arrives.
                if (link.snk_msg_valid && link.snk_msg == `PVI_MSG_GOODCRC) begin
                    next_r.st = SR_TRANS;   // see [RULE3]
                    next_r.cnt = '0;   // see [RULE11]
                end
            end
            SR_TRANS: begin
                if (r.cnt >= `PVI_CNT_W'(SNK_TRANS_CYC - 1)) begin
                    next_r.cmd = 1'b1;   // see [RULE4] see [RULE6]
                    next_r.cnt = '0;
                    next_r.st = SR_WAIT_SUPPLY;
                end else begin
                    next_r.cnt = r.cnt + 1'b1;   // see [RULE4]
                end
            end
            SR_WAIT_SUPPLY: begin
                // A late supply is flagged but still awaited, so the sequence ends cleanly.
                if (r.cnt < `PVI_CNT_W'(SRC_READY_CYC)) begin
                    next_r.cnt = r.cnt + 1'b1;
                end else begin
                    next_r.late = 1'b1;   // see [RULE6]
                end
                if (rdy_s2) begin
                    next_r.msg_v = 1'b1;
                    next_r.msg = `PVI_MSG_PS_RDY;   // see [RULE7]
                    next_r.st = SR_WAIT_ACK2;
                end
            end
            SR_WAIT_ACK2: begin
                if (link.snk_msg_valid && link.snk_msg == `PVI_MSG_GOODCRC) begin
                    next_r.done = 1'b1;   // see [RULE8]
                    next_r.st = SR_IDLE;
                end
            end
        endcase
        // Busy follows the next state so it rises with the Accept strobe.
        next_r.busy = (next_r.st != SR_IDLE);
    end

    // State register.
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            r <= '{st: SR_IDLE, default: '0};
        end else begin
            r <= next_r;
        end
    end

    assign link.src_msg_valid = r.msg_v;
    assign link.src_msg = r.msg;
    assign supply_cmd_o = r.cmd;
    assign busy_o = r.busy;
    assign done_o = r.done;
    assign ready_late_o = r.late;
endmodule // pvi_source
`default_nettype wire

// File: verification/pvi_link_checker.sv
// Concurrent checks on the link between the two sequencer ends.
`timescale 1ns/1ps
`default_nettype none
`include "pvi_params.svh"
module pvi_link_checker
    import pvi_pkg::*;
#(
    parameter int unsigned SNK_TRANS_CYC = `PVI_SNK_TRANSITION_CYC
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic src_msg_valid,
    input wire pvi_msg_t src_msg,
    input wire logic snk_msg_valid,
    input wire pvi_msg_t snk_msg
);
    // ------------------------------------------------------------------------
    // Helper state
    // ------------------------------------------------------------------------
    logic armed; // An Accept is out and its PS_RDY is not.
    logic [15:0] since; // Cycles since the last Accept; saturates so it never wraps.
    wire logic acc = src_msg_valid && (src_msg == `PVI_MSG_ACCEPT);
    wire logic rdy = src_msg_valid && (src_msg == `PVI_MSG_PS_RDY);
    // Opens on Accept and closes on PS_RDY.
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            armed <= 1'h0;
            since <= 16'h0000;
        end else begin
            armed <= acc || (armed && !rdy);
            since <= acc ? 16'h0000 : since + {15'h0000, since != 16'hFFFF};
        end
    end
    // ------------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);
    // One acknowledge from the sink.
    sequence ack_s;
        snk_msg_valid && (snk_msg == `PVI_MSG_GOODCRC);
    endsequence
    accept_ack_a: assert property (acc |=> ack_s) else $error("accept not acknowledged");
    psrdy_ack_a: assert property (rdy |=> ack_s) else $error("ps_rdy not acknowledged");
    ack_cause_a: assert property (snk_msg_valid |-> $past(src_msg_valid)) else $error("unprompted ack");
    ack_idle_a: assert property (!snk_msg_valid |-> snk_msg == `PVI_MSG_NONE) else $error("idle code");
    src_code_a: assert property (src_msg_valid |-> acc || rdy) else $error("bad source code");
    strobe_one_a: assert property (src_msg_valid |=> !src_msg_valid) else $error("long strobe");
    accept_once_a: assert property (acc |-> !armed) else $error("accept while busy");
    trans_wait_a: assert property (rdy |-> armed && since >= SNK_TRANS_CYC) else $error("early ps_rdy");
endmodule // pvi_link_checker
`default_nettype wire

// File: verification/pd_voltage_increase_sequencer_test.sv
// Bench joining the source and sink ends of the voltage-increase sequencer.
`timescale 1ns/1ps
`default_nettype none
module pd_voltage_increase_sequencer_test;
    import pvi_pkg::*;
    // ------------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------------
    localparam int unsigned SNK_TRANS = 8; // Short wait keeps the run brief.
    // Supply and standby delays, then the sticky late flags expected after the row.
    typedef struct {int rdy; int sb; logic rl; logic sl;} pvi_row_s;
    pvi_row_s rows [4] = '{'{3, 2, 1'h0, 1'h0}, '{0, 5, 1'h0, 1'h0}, '{40, 2, 1'h1, 1'h0}, '{3, 30, 1'h1, 1'h1}};
    logic clk_sys_i = 1'h0;
    logic resetn_i = 1'h0;
    logic req_accepted_i = 1'h0;
    logic supply_ready_i = 1'h0;
    logic stdby_reached_i = 1'h0;
    logic supply_cmd_o, busy_o, done_o, ready_late_o, stdby_req_o, new_level_ok_o, stdby_late_o, ps_timeout_o;
    int errors = 0;
    int n_checks = 0;
    int cycles = 0;
    wire logic [7:0] outs = {supply_cmd_o, busy_o, done_o, ready_late_o,
                             stdby_req_o, new_level_ok_o, stdby_late_o, ps_timeout_o};
    pvi_link_if link ();
    pvi_source #(.SNK_TRANS_CYC(SNK_TRANS), .SRC_READY_CYC(20)) pvi_source_i (.clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i), .link(link), .req_accepted_i(req_accepted_i), .supply_ready_i(supply_ready_i),
        .supply_cmd_o(supply_cmd_o), .busy_o(busy_o), .done_o(done_o), .ready_late_o(ready_late_o));
    pvi_sink #(.STDBY_CYC(10), .PS_TRANS_CYC(100)) pvi_sink_i (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
        .link(link), .stdby_reached_i(stdby_reached_i), .stdby_req_o(stdby_req_o),
        .new_level_ok_o(new_level_ok_o), .stdby_late_o(stdby_late_o), .ps_timeout_o(ps_timeout_o));
    pvi_link_checker #(.SNK_TRANS_CYC(SNK_TRANS)) pvi_link_checker_i (.clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i), .src_msg_valid(link.src_msg_valid), .src_msg(link.src_msg),
        .snk_msg_valid(link.snk_msg_valid), .snk_msg(link.snk_msg));
    // ------------------------------------------------------------------------
    // Clock, hang guard and helpers
    // ------------------------------------------------------------------------
    initial begin
        forever #25 clk_sys_i = ~clk_sys_i;
    end
    // A hang is cut short well beyond the few hundred cycles the whole run needs.
    always @(posedge clk_sys_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            errors++;
            finish_test();
        end
    end
    task automatic finish_test();
        if (errors == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    // One full transfer; the supply and standby answers come after the given delays.
    task automatic run_seq(input int rdy, input int sb);
        logic seen;
        @(posedge clk_sys_i);
        req_accepted_i <= 1'h1;
        @(posedge clk_sys_i);
        req_accepted_i <= 1'h0;
        fork
            begin
                for (int k = 0; k < 50 && stdby_req_o !== 1'h1; k++) @(negedge clk_sys_i);
                repeat (sb) @(posedge clk_sys_i);
                stdby_reached_i <= 1'h1;
            end
            begin
                repeat (SNK_TRANS + 3 + rdy) @(posedge clk_sys_i);
                supply_ready_i <= 1'h1;
            end
            begin
                for (int k = 0; k < 400 && done_o !== 1'h1; k++) @(negedge clk_sys_i);
                seen = done_o;
            end
        join
        @(negedge clk_sys_i);
        chk(seen, 1'h1);
        chk(new_level_ok_o, 1'h1);
        chk(stdby_req_o, 1'h0);
        chk(busy_o, 1'h0);
        @(posedge clk_sys_i);
        supply_ready_i <= 1'h0;
        stdby_reached_i <= 1'h0;
    endtask
    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clk_sys_i);
        resetn_i <= 1'h1;
        @(negedge clk_sys_i);
        for (int b = 0; b < 8; b++) chk(outs[b], 1'h0);
        foreach (rows[r]) begin
            run_seq(rows[r].rdy, rows[r].sb);
            chk(supply_cmd_o, 1'h1);
            chk(ready_late_o, rows[r].rl);
            chk(stdby_late_o, rows[r].sl);
        end
        // A very late supply trips the sink timer; a request mid-sequence must be ignored.
        fork
            run_seq(120, 2);
            begin
                repeat (6) @(posedge clk_sys_i);
                req_accepted_i <= 1'h1;
                @(posedge clk_sys_i);
                req_accepted_i <= 1'h0;
            end
        join
        chk(ps_timeout_o, 1'h1);
        // A reset between sequences clears every flag and level.
        @(posedge clk_sys_i);
        resetn_i <= 1'h0;
        @(negedge clk_sys_i);
        for (int b = 0; b < 8; b++) chk(outs[b], 1'h0);
        @(posedge clk_sys_i);
        resetn_i <= 1'h1;
        run_seq(3, 2);
        chk(ready_late_o, 1'h0);
        finish_test();
    end
endmodule // pd_voltage_increase_sequencer_test
`default_nettype wire
